// ---- cad_alu_map.vh ----
// Constants for the CPU ALU datapath: operation codes, sizes, flag positions.
// Assumes inclusion by the datapath module only.
`ifndef CAD_ALU_MAP_VH
`define CAD_ALU_MAP_VH

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define CAD_OP_DIVIDE_UNSIGNED 5'h00
`define CAD_OP_DIVIDE_SIGNED 5'h01
`define CAD_OP_COMPARE 5'h02
`define CAD_OP_NEGATE 5'h03
`define CAD_OP_SIGN_EXTEND 5'h04
`define CAD_OP_ZERO_EXTEND 5'h05
`define CAD_OP_AND 5'h06
`define CAD_OP_OR 5'h07
`define CAD_OP_XOR 5'h08
`define CAD_OP_NOT 5'h09
`define CAD_OP_ARITH_SHIFT_LEFT 5'h0A
`define CAD_OP_ARITH_SHIFT_RIGHT 5'h0B
`define CAD_OP_LOGIC_SHIFT_LEFT 5'h0C
`define CAD_OP_LOGIC_SHIFT_RIGHT 5'h0D
`define CAD_OP_ROTATE_LEFT 5'h0E
`define CAD_OP_ROTATE_RIGHT 5'h0F
`define CAD_OP_ROTATE_LEFT_VIA_CARRY 5'h10
`define CAD_OP_ROTATE_RIGHT_VIA_CARRY 5'h11
`define CAD_OP_BIT_SET 5'h12
`define CAD_OP_BIT_CLEAR 5'h13
`define CAD_OP_BIT_INVERT 5'h14
`define CAD_OP_BIT_TEST 5'h15
`define CAD_OP_CARRY_AND_BIT 5'h16
`define CAD_OP_CARRY_AND_INVERTED_BIT 5'h17

// ----------------------------------------------------------------------------
// Operand sizes
// ----------------------------------------------------------------------------
`define CAD_SZ_BYTE 2'h0
`define CAD_SZ_WORD 2'h1
`define CAD_SZ_LONG 2'h2

// ----------------------------------------------------------------------------
// Flag positions and reset values
// ----------------------------------------------------------------------------
`define CAD_FLAG_N 3
`define CAD_FLAG_Z 2
`define CAD_FLAG_V 1
`define CAD_FLAG_C 0
`define CAD_FLAGS_RESET 4'h0
`define CAD_REG_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Divider step counts
// ----------------------------------------------------------------------------
`define CAD_DIV_STEPS_BYTE 6'h10
`define CAD_DIV_STEPS_WORD 6'h20

`endif

// ---- cad_alu.v ----
// CPU execution datapath: divide, compare, negate, extend, logic, shift,
// rotate and bit operations, with the general register file and flags.
// Assumes a decoder on the same clock that holds no operation open while busy.
//
// What this block does
// - Unsigned divide 16/8 and 32/16 from registers
// - Signed two's complement divide, same two sizes
// - Compare subtracts, updates flags only
// - Negate replaces register with zero minus it
// - Sign extend byte to word, word to long
// - Zero extend clears upper part, keeps low
// - AND register with register or immediate
// - OR register with register or immediate
// - XOR register with register or immediate
// - NOT inverts every bit of the sized register view
// - Byte/word/long sizes; limits for divide, extend, bits
// - Arithmetic shifts; right shift keeps sign
// - Logical shifts fill vacated bit with zero
// - Rotates feed out bit back in
// - Rotates through carry use carry as extra bit
// - Set selected bit of byte operand
// - Clear selected bit of byte operand
// - Invert selected bit of byte operand
// - Bit test loads zero flag, operand unchanged
// - Bit number from immediate or register low bits
// - Carry ANDed with selected bit
// - Carry ANDed with inverted bit, immediate number only
// - Registers as byte, word and long views
// - Keep negative, zero, overflow, carry flags
`timescale 1ns/1ps
`default_nettype none
`include "cad_alu_map.vh"

module cad_alu (
  // Clock and reset
  input wire CLOCK_I,
  input wire RESET_N_I,
  // Operation request
  input wire OP_START_I,
  input wire [4:0] OP_CODE_I,
  input wire [1:0] OP_SIZE_I,
  input wire [3:0] DST_SEL_I,
  input wire [3:0] SRC_SEL_I,
  input wire SRC_IS_IMM_I,
  input wire [31:0] IMM_I,
  input wire [2:0] BIT_NUM_I,
  input wire BIT_NUM_FROM_REG_I,
  input wire MEM_OPERAND_I,
  output wire BUSY_O,
  output reg DONE_O,
  output reg ILLEGAL_O,
  // Memory byte operand
  output wire MEM_RD_REQ_O,
  input wire MEM_RD_VALID_I,
  input wire [7:0] MEM_RD_DATA_I,
  output reg MEM_WR_REQ_O,
  output reg [7:0] MEM_WR_DATA_O,
  // Register load and view
  input wire REG_WR_EN_I,
  input wire [2:0] REG_WR_SEL_I,
  input wire [31:0] REG_WR_DATA_I,
  input wire [2:0] REG_RD_SEL_I,
  output reg [31:0] REG_RD_DATA_O,
  output wire [3:0] FLAGS_O
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_MEM = 2'h2;
  localparam ST_DIV = 2'h3;

  // Byte: sel[3] low half else high; word: sel[3] upper else lower
  function [31:0] view_get;
    input [31:0] r;
    input [3:0] sel;
    input [1:0] sz;
    begin
      case (sz)
        `CAD_SZ_BYTE: view_get = {24'h000000, sel[3] ? r[7:0] : r[15:8]};
        `CAD_SZ_WORD: view_get = {16'h0000, sel[3] ? r[31:16] : r[15:0]};
        default: view_get = r;
      endcase
    end
  endfunction

  function [31:0] view_put;
    input [31:0] r;
    input [31:0] v;
    input [3:0] sel;
    input [1:0] sz;
    begin
      case (sz)
        `CAD_SZ_BYTE: view_put = sel[3] ? {r[31:8], v[7:0]} : {r[31:16], v[7:0], r[7:0]};
        `CAD_SZ_WORD: view_put = sel[3] ? {v[15:0], r[15:0]} : {r[31:16], v[15:0]};
        default: view_put = v;
      endcase
    end
  endfunction

  function [31:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `CAD_SZ_BYTE: size_mask = 32'h000000FF;
        `CAD_SZ_WORD: size_mask = 32'h0000FFFF;
        default: size_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  function top_bit;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `CAD_SZ_BYTE: top_bit = v[7];
        `CAD_SZ_WORD: top_bit = v[15];
        default: top_bit = v[31];
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [31:0] gpr_reg [0:7];
  reg [3:0] flags_reg;
  reg [1:0] state_reg;
  reg [4:0] op_reg;
  reg [1:0] size_reg;
  reg [3:0] dst_reg;
  reg [31:0] src_reg;
  reg [2:0] bitn_reg;
  reg [5:0] step_reg;
  reg [31:0] quo_reg;
  reg [16:0] rem_reg;
  reg dvd_neg_reg;
  reg q_neg_reg;
  integer i;

  wire [1:0] dsize = (op_reg == `CAD_OP_DIVIDE_UNSIGNED || op_reg == `CAD_OP_DIVIDE_SIGNED) ?
                     size_reg + 2'h1 : size_reg;
  wire [31:0] dst_long = gpr_reg[dst_reg[2:0]];
  wire [31:0] d = view_get(dst_long, dst_reg, dsize);
  wire [31:0] s = src_reg;
  wire [31:0] m = size_mask(size_reg);
  wire cflag = flags_reg[`CAD_FLAG_C];
  wire is_div = (OP_CODE_I == `CAD_OP_DIVIDE_UNSIGNED) || (OP_CODE_I == `CAD_OP_DIVIDE_SIGNED);
  wire is_ext = (OP_CODE_I == `CAD_OP_SIGN_EXTEND) || (OP_CODE_I == `CAD_OP_ZERO_EXTEND);
  wire is_bit = (OP_CODE_I >= `CAD_OP_BIT_SET) && (OP_CODE_I <= `CAD_OP_CARRY_AND_INVERTED_BIT);
  wire illegal = (OP_CODE_I > `CAD_OP_CARRY_AND_INVERTED_BIT) || (OP_SIZE_I > `CAD_SZ_LONG) ||
                 (is_div && OP_SIZE_I == `CAD_SZ_LONG) ||
                 (is_ext && OP_SIZE_I == `CAD_SZ_BYTE) ||
                 (is_bit && OP_SIZE_I != `CAD_SZ_BYTE) ||
                 (OP_CODE_I == `CAD_OP_CARRY_AND_INVERTED_BIT && BIT_NUM_FROM_REG_I) ||
                 (MEM_OPERAND_I && !is_bit);
  wire [31:0] src_view = view_get(gpr_reg[SRC_SEL_I[2:0]], SRC_SEL_I, OP_SIZE_I);
  wire start = OP_START_I && (state_reg == ST_IDLE);

  // Divider: magnitudes and one restoring step
  wire [15:0] dvs_mag = s[15:0];
  wire [16:0] rem_shift = {rem_reg[15:0], quo_reg[31]};
  wire rem_ge = rem_shift >= {1'b0, dvs_mag};
  wire [31:0] quo_fin = q_neg_reg ? (32'h0 - quo_reg) : quo_reg;
  wire [16:0] rem_fin = dvd_neg_reg ? (17'h0 - rem_reg) : rem_reg;

  // --------------------------------------------------------------------------
  // Execute
  // --------------------------------------------------------------------------
  reg [31:0] res;
  reg [3:0] flg;
  reg wr;
  reg in_bit;
  reg [7:0] opb;
  reg [7:0] bres;
  reg bsel;
  always @* begin
    res = d;
    flg = flags_reg;
    wr = 1'b0;
    in_bit = 1'b0;
    opb = (state_reg == ST_MEM) ? MEM_RD_DATA_I : d[7:0];
    bsel = opb[bitn_reg];
    bres = opb;
    case (op_reg)
      `CAD_OP_COMPARE, `CAD_OP_NEGATE: begin
        if (op_reg == `CAD_OP_COMPARE) begin
          res = (d - s) & m;
          flg[`CAD_FLAG_C] = (s & m) > (d & m);
          flg[`CAD_FLAG_V] = (top_bit(d, size_reg) ^ top_bit(s, size_reg)) &
                             (top_bit(res, size_reg) ^ top_bit(d, size_reg));
        end else begin
          res = (32'h0 - d) & m;
          wr = 1'b1;
          flg[`CAD_FLAG_C] = (d & m) != 32'h0;
          flg[`CAD_FLAG_V] = top_bit(d, size_reg) & top_bit(res, size_reg);
        end
      end
      `CAD_OP_SIGN_EXTEND: begin
        res = (size_reg == `CAD_SZ_WORD) ? {{24{d[7]}}, d[7:0]} : {{16{d[15]}}, d[15:0]};
        wr = 1'b1;
        flg[`CAD_FLAG_V] = 1'b0;
      end
      `CAD_OP_ZERO_EXTEND: begin
        res = (size_reg == `CAD_SZ_WORD) ? {24'h000000, d[7:0]} : {16'h0000, d[15:0]};
        wr = 1'b1;
        flg[`CAD_FLAG_V] = 1'b0;
      end
      `CAD_OP_AND, `CAD_OP_OR, `CAD_OP_XOR, `CAD_OP_NOT: begin
        case (op_reg)
          `CAD_OP_AND: res = d & s;
          `CAD_OP_OR: res = d | s;
          `CAD_OP_XOR: res = d ^ s;
          default: res = ~d & m;
        endcase
        wr = 1'b1;
        flg[`CAD_FLAG_V] = 1'b0;
      end
      `CAD_OP_ARITH_SHIFT_LEFT, `CAD_OP_LOGIC_SHIFT_LEFT, `CAD_OP_ROTATE_LEFT,
      `CAD_OP_ROTATE_LEFT_VIA_CARRY: begin
        if (op_reg == `CAD_OP_ROTATE_LEFT) in_bit = top_bit(d, size_reg);
        else if (op_reg == `CAD_OP_ROTATE_LEFT_VIA_CARRY) in_bit = cflag;
        res = ({d[30:0], in_bit}) & m;
        wr = 1'b1;
        flg[`CAD_FLAG_C] = top_bit(d, size_reg);
        flg[`CAD_FLAG_V] = (op_reg == `CAD_OP_ARITH_SHIFT_LEFT) &&
                           (top_bit(d, size_reg) != top_bit(res, size_reg));
      end
      `CAD_OP_ARITH_SHIFT_RIGHT, `CAD_OP_LOGIC_SHIFT_RIGHT, `CAD_OP_ROTATE_RIGHT,
      `CAD_OP_ROTATE_RIGHT_VIA_CARRY: begin
        if (op_reg == `CAD_OP_ARITH_SHIFT_RIGHT) in_bit = top_bit(d, size_reg);
        else if (op_reg == `CAD_OP_ROTATE_RIGHT) in_bit = d[0];
        else if (op_reg == `CAD_OP_ROTATE_RIGHT_VIA_CARRY) in_bit = cflag;
        res = ((d & m) >> 1) | ({31'h0, in_bit} << (size_reg == `CAD_SZ_BYTE ? 7 :
              size_reg == `CAD_SZ_WORD ? 15 : 31));
        wr = 1'b1;
        flg[`CAD_FLAG_C] = d[0];
        flg[`CAD_FLAG_V] = 1'b0;
      end
      `CAD_OP_BIT_SET: begin
        bres[bitn_reg] = 1'b1;
        wr = 1'b1;
      end
      `CAD_OP_BIT_CLEAR: begin
        bres[bitn_reg] = 1'b0;
        wr = 1'b1;
      end
      `CAD_OP_BIT_INVERT: begin
        bres[bitn_reg] = ~bsel;
        wr = 1'b1;
      end
      `CAD_OP_BIT_TEST: flg[`CAD_FLAG_Z] = ~bsel;
      `CAD_OP_CARRY_AND_BIT: flg[`CAD_FLAG_C] = cflag & bsel;
      `CAD_OP_CARRY_AND_INVERTED_BIT: flg[`CAD_FLAG_C] = cflag & ~bsel;
      default: res = d;
    endcase
    if (op_reg >= `CAD_OP_BIT_SET) begin
      res = {24'h000000, bres};
    end else if (op_reg >= `CAD_OP_COMPARE) begin
      flg[`CAD_FLAG_N] = top_bit(res, size_reg);
      flg[`CAD_FLAG_Z] = (res & m) == 32'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer and storage
  // --------------------------------------------------------------------------
  always @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (i = 0; i < 8; i = i + 1) begin
        gpr_reg[i] <= `CAD_REG_RESET;
      end
      flags_reg <= `CAD_FLAGS_RESET;
      state_reg <= ST_IDLE;
      op_reg <= 5'h00;
      size_reg <= `CAD_SZ_BYTE;
      dst_reg <= 4'h0;
      src_reg <= 32'h00000000;
      bitn_reg <= 3'h0;
      step_reg <= 6'h00;
      quo_reg <= 32'h00000000;
      rem_reg <= 17'h00000;
      dvd_neg_reg <= 1'b0;
      q_neg_reg <= 1'b0;
      DONE_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
      MEM_WR_REQ_O <= 1'b0;
      MEM_WR_DATA_O <= 8'h00;
      REG_RD_DATA_O <= 32'h00000000;
    end else begin
      DONE_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
      MEM_WR_REQ_O <= 1'b0;
      REG_RD_DATA_O <= gpr_reg[REG_RD_SEL_I];
      if (REG_WR_EN_I) begin
        gpr_reg[REG_WR_SEL_I] <= REG_WR_DATA_I;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start && illegal) begin
            DONE_O <= 1'b1;
            ILLEGAL_O <= 1'b1;
          end else if (start) begin
            op_reg <= OP_CODE_I;
            size_reg <= OP_SIZE_I;
            dst_reg <= DST_SEL_I;
            src_reg <= SRC_IS_IMM_I ? (IMM_I & size_mask(OP_SIZE_I)) : src_view;
            bitn_reg <= BIT_NUM_FROM_REG_I ? src_view[2:0] : BIT_NUM_I;
            state_reg <= MEM_OPERAND_I ? ST_MEM : ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (op_reg == `CAD_OP_DIVIDE_UNSIGNED || op_reg == `CAD_OP_DIVIDE_SIGNED) begin
            if (op_reg == `CAD_OP_DIVIDE_SIGNED && size_reg == `CAD_SZ_BYTE) begin
              quo_reg <= {(d[15] ? 16'h0 - d[15:0] : d[15:0]), 16'h0000};
              src_reg <= {24'h000000, s[7] ? 8'h0 - s[7:0] : s[7:0]};
              dvd_neg_reg <= d[15];
              q_neg_reg <= d[15] ^ s[7];
            end else if (op_reg == `CAD_OP_DIVIDE_SIGNED) begin
              quo_reg <= d[31] ? 32'h0 - d : d;
              src_reg <= {16'h0000, s[15] ? 16'h0 - s[15:0] : s[15:0]};
              dvd_neg_reg <= d[31];
              q_neg_reg <= d[31] ^ s[15];
            end else begin
              quo_reg <= (size_reg == `CAD_SZ_BYTE) ? {d[15:0], 16'h0000} : d;
              dvd_neg_reg <= 1'b0;
              q_neg_reg <= 1'b0;
            end
            rem_reg <= 17'h00000;
            step_reg <= (size_reg == `CAD_SZ_BYTE) ? `CAD_DIV_STEPS_BYTE : `CAD_DIV_STEPS_WORD;
            if ((s & m) == 32'h0) begin
              flags_reg[`CAD_FLAG_N] <= 1'b0;
              flags_reg[`CAD_FLAG_Z] <= 1'b1;
              state_reg <= ST_IDLE;
              DONE_O <= 1'b1;
            end else begin
              state_reg <= ST_DIV;
            end
          end else begin
            flags_reg <= flg;
            if (wr) begin
              gpr_reg[dst_reg[2:0]] <= view_put(dst_long, res, dst_reg, size_reg);
            end
            state_reg <= ST_IDLE;
            DONE_O <= 1'b1;
          end
        end
        ST_MEM: begin
          if (MEM_RD_VALID_I) begin
            flags_reg <= flg;
            MEM_WR_REQ_O <= wr;
            MEM_WR_DATA_O <= bres;
            state_reg <= ST_IDLE;
            DONE_O <= 1'b1;
          end
        end
        default: begin
          if (step_reg != 6'h00) begin
            rem_reg <= rem_ge ? rem_shift - {1'b0, dvs_mag} : rem_shift;
            quo_reg <= {quo_reg[30:0], rem_ge};
            step_reg <= step_reg - 6'h01;
          end else begin
            if (size_reg == `CAD_SZ_BYTE) begin
              gpr_reg[dst_reg[2:0]] <= view_put(dst_long, {16'h0000, rem_fin[7:0], quo_fin[7:0]},
                                                dst_reg, `CAD_SZ_WORD);
            end else begin
              gpr_reg[dst_reg[2:0]] <= {rem_fin[15:0], quo_fin[15:0]};
            end
            // Divisor sign, flags move only with done
            flags_reg[`CAD_FLAG_N] <= (op_reg == `CAD_OP_DIVIDE_SIGNED) ? (q_neg_reg ^ dvd_neg_reg) :
                                      top_bit(s, size_reg);
            flags_reg[`CAD_FLAG_Z] <= 1'b0;
            state_reg <= ST_IDLE;
            DONE_O <= 1'b1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign BUSY_O = state_reg != ST_IDLE;
  assign MEM_RD_REQ_O = state_reg == ST_MEM;
  assign FLAGS_O = flags_reg;

endmodule // cad_alu

`default_nettype wire

// ---- cad_mem_model.sv ----
// Memory byte responder on the datapath's byte port.
// Assumes the read request is held until valid is seen, same clock.
`timescale 1ns/1ps
`default_nettype none
module cad_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Byte port
  input wire logic rd_req_i,
  input wire logic wr_req_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [3:0] lat_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  // Preloaded byte for the first bit operation
  logic [7:0] mem_q = 8'h10;
  logic [3:0] cnt_q;
  integer wr_count = 0;
  // Idle data shows the inverse
  assign rd_data_o = rd_valid_o ? mem_q : ~mem_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      cnt_q <= 4'h0;
    end else if (rd_req_i && !rd_valid_o) begin
      rd_valid_o <= (cnt_q == lat_i);
      cnt_q <= cnt_q + 4'h1;
    end else begin
      rd_valid_o <= 1'b0;
      cnt_q <= 4'h0;
    end
  end
  always @(posedge clk_i) begin
    if (wr_req_i) begin
      mem_q <= wr_data_i;
      wr_count <= wr_count + 1;
    end
  end
endmodule // cad_mem_model
`default_nettype wire

// ---- cad_alu_properties.sv ----
// Checker on the datapath's top ports.
// Assumes binding to cad_alu on its single clock.
`timescale 1ns/1ps
`default_nettype none
module cad_alu_chk (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // Watched ports
  input wire logic OP_START_I,
  input wire logic [4:0] OP_CODE_I,
  input wire logic [1:0] OP_SIZE_I,
  input wire logic MEM_OPERAND_I,
  input wire logic MEM_RD_VALID_I,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic ILLEGAL_O,
  input wire logic MEM_RD_REQ_O,
  input wire logic MEM_WR_REQ_O,
  input wire logic [3:0] FLAGS_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  wire take = OP_START_I && !BUSY_O;
  wire bit_op = OP_CODE_I >= 5'h12 && OP_CODE_I <= 5'h16;
  chk_illegal_done: assert property (ILLEGAL_O |-> DONE_O && !MEM_WR_REQ_O)
    else $error("illegal pulse without done");
  chk_size_refused: assert property (take && OP_SIZE_I == 2'h3 |=> ILLEGAL_O && DONE_O)
    else $error("size code 3 not refused");
  chk_and_timing: assert property (take && OP_CODE_I == 5'h06 && OP_SIZE_I != 2'h3 && !MEM_OPERAND_I
    |=> BUSY_O && !DONE_O ##1 DONE_O && !ILLEGAL_O) else $error("logic op timing wrong");
  chk_div_long_bad: assert property (take && OP_CODE_I <= 5'h01 && OP_SIZE_I == 2'h2 |=> ILLEGAL_O)
    else $error("long divide not refused");
  chk_ext_byte_bad: assert property (take && (OP_CODE_I == 5'h04 || OP_CODE_I == 5'h05)
    && OP_SIZE_I == 2'h0 |=> ILLEGAL_O) else $error("byte extend not refused");
  chk_bit_word_bad: assert property (take && bit_op && OP_SIZE_I != 2'h0 |=> ILLEGAL_O)
    else $error("bit op on wide operand not refused");
  chk_mem_read_start: assert property (take && bit_op && OP_SIZE_I == 2'h0 && MEM_OPERAND_I
    |=> MEM_RD_REQ_O && BUSY_O) else $error("memory read not requested");
  chk_mem_read_end: assert property (MEM_RD_REQ_O && MEM_RD_VALID_I |=> DONE_O && !MEM_RD_REQ_O)
    else $error("memory read not finished");
  chk_write_with_done: assert property (MEM_WR_REQ_O |-> DONE_O && !ILLEGAL_O)
    else $error("write back outside done");
  chk_flags_at_done: assert property ($changed(FLAGS_O) |-> DONE_O)
    else $error("flags changed outside done");
endmodule // cad_alu_chk
bind cad_alu cad_alu_chk cad_alu_chk_i (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .OP_START_I(OP_START_I),
  .OP_CODE_I(OP_CODE_I), .OP_SIZE_I(OP_SIZE_I), .MEM_OPERAND_I(MEM_OPERAND_I), .MEM_RD_VALID_I(MEM_RD_VALID_I),
  .BUSY_O(BUSY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .MEM_RD_REQ_O(MEM_RD_REQ_O),
  .MEM_WR_REQ_O(MEM_WR_REQ_O), .FLAGS_O(FLAGS_O));
`default_nettype wire

// ---- cad_alu_bench.sv ----
// Self-checking bench for the datapath.
// Assumes the memory model stands on the byte port.
`timescale 1ns/1ps
`default_nettype none
module cad_alu_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0, isimm = 1'b0, bfr = 1'b0, mo = 1'b0, wen = 1'b0, ill_seen;
  logic [4:0] code = 5'h00;
  logic [1:0] sz = 2'h0;
  logic [3:0] dst = 4'h0, src = 4'h0, lat = 4'h0, flags;
  logic [31:0] imm = 32'h0, wdat = 32'h0, rv, rdata;
  logic [2:0] bn = 3'h0, wsel = 3'h0, rsel = 3'h0;
  logic [7:0] sin [8] = '{8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h85, 8'h04, 8'h80};
  logic [7:0] sout [8] = '{8'h0A, 8'hC2, 8'h0A, 8'h42, 8'h0B, 8'hC2, 8'h82, 8'h00};
  logic [4:0] sop [8] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h10};
  logic [7:0] sc = 8'hBF;
  wire busy, done, ill, rvld, rreq, wreq;
  wire [7:0] rdat, wbyte;
  integer mismatches = 0, checked = 0, cyc = 0, k, i;
  always #12.5 clk = ~clk;
  cad_alu cad_alu_i (.CLOCK_I(clk), .RESET_N_I(rst_n), .OP_START_I(start), .OP_CODE_I(code), .OP_SIZE_I(sz),
    .DST_SEL_I(dst), .SRC_SEL_I(src), .SRC_IS_IMM_I(isimm), .IMM_I(imm), .BIT_NUM_I(bn),
    .BIT_NUM_FROM_REG_I(bfr), .MEM_OPERAND_I(mo), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill),
    .MEM_RD_REQ_O(rreq), .MEM_RD_VALID_I(rvld), .MEM_RD_DATA_I(rdat), .MEM_WR_REQ_O(wreq),
    .MEM_WR_DATA_O(wbyte), .REG_WR_EN_I(wen), .REG_WR_SEL_I(wsel), .REG_WR_DATA_I(wdat),
    .REG_RD_SEL_I(rsel), .REG_RD_DATA_O(rdata), .FLAGS_O(flags));
  cad_mem_model cad_mem_model_i (.clk_i(clk), .rst_n_i(rst_n), .rd_req_i(rreq), .wr_req_i(wreq),
    .wr_data_i(wbyte), .lat_i(lat), .rd_valid_o(rvld), .rd_data_o(rdat));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task wrap_up;
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task ld(input [2:0] s, input [31:0] v);
    @(negedge clk);
    wen = 1'b1;
    wsel = s;
    wdat = v;
    @(negedge clk);
    wen = 1'b0;
  endtask
  task rd(input [2:0] s);
    @(negedge clk);
    rsel = s;
    @(negedge clk);
    rv = rdata;
  endtask
  task wt;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge clk);
      k = k + 1;
    end
    ill_seen = ill;
    if (k == 60) begin
      mismatches = mismatches + 1;
      $display("Error at %0t seen %h expected %h", $time, 0, 1);
    end
  endtask
  task go(input [4:0] c, input [1:0] z, input [3:0] d, input [3:0] s, input m, input [31:0] v);
    @(negedge clk);
    code = c;
    sz = z;
    dst = d;
    src = s;
    isimm = m;
    imm = v;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    wt;
  endtask
  task gor(input [4:0] c, input [1:0] z, input [3:0] d, input [3:0] s, input m, input [31:0] v,
           input [2:0] r, input [31:0] e, input [3:0] fm, input [3:0] fe);
    go(c, z, d, s, m, v);
    rd(r);
    chk(rv, e);
    chk({28'h0, flags & fm}, {28'h0, fe});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task s_div;
    ld(3'h1, 32'h0064);
    ld(3'h2, 32'h0007);
    gor(5'h00, 2'h0, 4'h1, 4'hA, 1'b0, 32'h0, 3'h1, 32'h020E, 4'hC, 4'h0);
    ld(3'h1, 32'hFF9C);
    gor(5'h01, 2'h0, 4'h1, 4'hA, 1'b0, 32'h0, 3'h1, 32'hFEF2, 4'hC, 4'h0);
    ld(3'h1, 32'h0064);
    ld(3'h2, 32'h00F9);
    gor(5'h01, 2'h0, 4'h1, 4'hA, 1'b0, 32'h0, 3'h1, 32'h02F2, 4'hC, 4'h8);
    ld(3'h3, 32'h00010000);
    ld(3'h4, 32'h0003);
    gor(5'h00, 2'h1, 4'h3, 4'h4, 1'b0, 32'h0, 3'h3, 32'h00015555, 4'h0, 4'h0);
    ld(3'h3, 32'hFFFF0000);
    gor(5'h01, 2'h1, 4'h3, 4'h4, 1'b0, 32'h0, 3'h3, 32'hFFFFAAAB, 4'h0, 4'h0);
    go(5'h00, 2'h2, 4'h3, 4'h4, 1'b0, 32'h0);
    chk(32'(ill_seen), 32'h1);
  endtask
  task s_cmp;
    ld(3'h0, 32'h0005);
    gor(5'h02, 2'h0, 4'h8, 4'h0, 1'b1, 32'h05, 3'h0, 32'h0005, 4'hF, 4'h4);
    gor(5'h02, 2'h0, 4'h8, 4'h0, 1'b1, 32'h06, 3'h0, 32'h0005, 4'hF, 4'h9);
    gor(5'h03, 2'h1, 4'h0, 4'h0, 1'b0, 32'h0, 3'h0, 32'hFFFB, 4'hF, 4'h9);
    gor(5'h03, 2'h2, 4'h0, 4'h0, 1'b0, 32'h0, 3'h0, 32'hFFFF0005, 4'hF, 4'h9);
    gor(5'h02, 2'h2, 4'h0, 4'h0, 1'b0, 32'h0, 3'h0, 32'hFFFF0005, 4'hF, 4'h4);
  endtask
  task s_ext;
    ld(3'h5, 32'h12345680);
    gor(5'h04, 2'h1, 4'h5, 4'h0, 1'b0, 32'h0, 3'h5, 32'h1234FF80, 4'hE, 4'h8);
    gor(5'h04, 2'h2, 4'h5, 4'h0, 1'b0, 32'h0, 3'h5, 32'hFFFFFF80, 4'hE, 4'h8);
    gor(5'h05, 2'h1, 4'h5, 4'h0, 1'b0, 32'h0, 3'h5, 32'hFFFF0080, 4'hE, 4'h0);
    gor(5'h05, 2'h2, 4'h5, 4'h0, 1'b0, 32'h0, 3'h5, 32'h00000080, 4'hE, 4'h0);
    go(5'h04, 2'h0, 4'h5, 4'h0, 1'b0, 32'h0);
    chk(32'(ill_seen), 32'h1);
  endtask
  task s_logic;
    ld(3'h6, 32'hF0F0F0F0);
    gor(5'h06, 2'h0, 4'hE, 4'h0, 1'b1, 32'hFFFFFF3C, 3'h6, 32'hF0F0F030, 4'hE, 4'h0);
    gor(5'h07, 2'h1, 4'h6, 4'h0, 1'b1, 32'h0F0F, 3'h6, 32'hF0F0FF3F, 4'hE, 4'h8);
    gor(5'h08, 2'h2, 4'h6, 4'h5, 1'b0, 32'h0, 3'h6, 32'hF0F0FFBF, 4'hE, 4'h8);
    gor(5'h09, 2'h0, 4'h6, 4'h0, 1'b0, 32'h0, 3'h6, 32'hF0F000BF, 4'hE, 4'h4);
  endtask
  task s_shift;
    for (i = 0; i < 8; i = i + 1) begin
      ld(3'h7, {24'h0, sin[i]});
      gor(sop[i], 2'h0, 4'hF, 4'h0, 1'b0, 32'h0, 3'h7, {24'h0, sout[i]}, 4'h1, {3'h0, sc[i]});
    end
    ld(3'h7, 32'h8001);
    gor(5'h0B, 2'h1, 4'h7, 4'h0, 1'b0, 32'h0, 3'h7, 32'hC000, 4'h9, 4'h9);
    ld(3'h7, 32'h80000001);
    gor(5'h0C, 2'h2, 4'h7, 4'h0, 1'b0, 32'h0, 3'h7, 32'h00000002, 4'h1, 4'h1);
  endtask
  task s_bits;
    ld(3'h4, 32'h000F);
    bn = 3'h7;
    gor(5'h12, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008F, 4'h0, 4'h0);
    bfr = 1'b1;
    gor(5'h13, 2'h0, 4'hC, 4'hA, 1'b0, 32'h0, 3'h4, 32'h008D, 4'h0, 4'h0);
    bfr = 1'b0;
    bn = 3'h0;
    gor(5'h14, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008C, 4'h0, 4'h0);
    gor(5'h15, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008C, 4'h4, 4'h4);
    bn = 3'h7;
    gor(5'h15, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008C, 4'h4, 4'h0);
    gor(5'h02, 2'h0, 4'hC, 4'h0, 1'b1, 32'hFF, 3'h4, 32'h008C, 4'h1, 4'h1);
    bn = 3'h2;
    gor(5'h16, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008C, 4'h1, 4'h1);
    gor(5'h17, 2'h0, 4'hC, 4'h0, 1'b0, 32'h0, 3'h4, 32'h008C, 4'h1, 4'h0);
    bfr = 1'b1;
    go(5'h17, 2'h0, 4'hC, 4'hA, 1'b0, 32'h0);
    chk(32'(ill_seen), 32'h1);
    bfr = 1'b0;
  endtask
  task s_mem;
    mo = 1'b1;
    bn = 3'h3;
    go(5'h12, 2'h0, 4'h0, 4'h0, 1'b0, 32'h0);
    @(negedge clk);
    chk({24'h0, cad_mem_model_i.mem_q}, 32'h18);
    lat = 4'h5;
    bn = 3'h4;
    go(5'h15, 2'h0, 4'h0, 4'h0, 1'b0, 32'h0);
    chk({28'h0, flags & 4'h4}, 32'h0);
    chk(cad_mem_model_i.wr_count, 32'h1);
    lat = 4'h2;
    bn = 3'h3;
    go(5'h14, 2'h0, 4'h0, 4'h0, 1'b0, 32'h0);
    @(negedge clk);
    chk({24'h0, cad_mem_model_i.mem_q}, 32'h10);
    go(5'h06, 2'h0, 4'h8, 4'h0, 1'b1, 32'h0);
    chk(32'(ill_seen), 32'h1);
    mo = 1'b0;
  endtask
  task s_refuse;
    ld(3'h1, 32'h0064);
    ld(3'h2, 32'h0007);
    go(5'h00, 2'h0, 4'h1, 4'hA, 1'b0, 32'h0);
    @(negedge clk);
    code = 5'h00;
    start = 1'b1;
    @(negedge clk);
    code = 5'h09;
    dst = 4'h6;
    repeat (4) @(negedge clk);
    start = 1'b0;
    wt;
    rd(3'h6);
    chk(rv, 32'hF0F000BF);
    rd(3'h1);
    chk(rv, 32'h014B);
    go(5'h18, 2'h0, 4'h0, 4'h0, 1'b0, 32'h0);
    chk(32'(ill_seen), 32'h1);
    go(5'h06, 2'h3, 4'h8, 4'h0, 1'b1, 32'h0);
    chk(32'(ill_seen), 32'h1);
    go(5'h12, 2'h1, 4'h8, 4'h0, 1'b0, 32'h0);
    chk(32'(ill_seen), 32'h1);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence and timeout
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    s_div;
    s_cmp;
    s_ext;
    s_logic;
    s_shift;
    s_bits;
    s_mem;
    s_refuse;
    wrap_up;
  end
endmodule // cad_alu_bench
`default_nettype wire
